// ===== rtl/host_link_params.svh
/*
 Register offsets, field positions and reset values of the host link and
 interrupt pin configuration block. Assumes 8-bit registers on an 8-bit address.
*/
`ifndef HOST_LINK_PARAMS_SVH
`define HOST_LINK_PARAMS_SVH

`define HLC_OFFSET 8'h31
`define IPC_OFFSET 8'h33
`define IST_OFFSET 8'h14
`define HLC_RESET 8'h00
`define IPC_RESET 8'h00
`define IST_RESET 8'h00
`define HLC_READ_MASK 8'hFC
`define HLC_SLEW_EN_BIT 2
`define HLC_SLEW_MAN_BIT 3
`define HLC_ROUTE_XCHG_BIT 4
`define HLC_SHARED_PIN_BIT 5
`define HLC_PER_SRC_CLR_BIT 6
`define IPC_PIN1_HIGH_BIT 2
`define IPC_PIN1_PP_BIT 3
`define IPC_PIN2_HIGH_BIT 6
`define IPC_PIN2_PP_BIT 7

`endif

// ===== rtl/host_link_pkg.sv
/*
 Types shared by the host link configuration block and its pin driver.
 Assumes the params header sits on the include path.
*/
package host_link_pkg;
    // register access from the serial port front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // one physical irq pin: level out, enable low while driving
    typedef struct packed {
        logic level;
        logic oe_n;
    } pin_drive_t;

    typedef enum logic [1:0] {
        SLEW_OFF = 2'b00,
        SLEW_ON = 2'b01,
        SLEW_AUTO = 2'b10
    } slew_mode_t;
endpackage

// ===== rtl/irq_pin_driver.sv
/*
 Drives one interrupt pin from a request, a polarity and a drive mode.
 Assumes request is a clean level on clk; the pad resolves the wire.
*/
`timescale 1ns/1ps
module irq_pin_driver (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pin settings
    input wire logic request,
    input wire logic level_high,
    input wire logic push_pull,
    // pad
    output host_link_pkg::pin_drive_t pin
);
    import host_link_pkg::*;

    logic active_lvl;
    assign active_lvl = request ? level_high : ~level_high;

    // open drain pulls only low; released means the pullup wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin <= '{level: 1'b1, oe_n: 1'b1};
        end else if (push_pull) begin
            pin <= '{level: active_lvl, oe_n: 1'b0};
        end else begin
            pin <= '{level: 1'b0, oe_n: active_lvl};
        end
    end

    pp_drives_a: assert property (@(posedge clk) disable iff (!rst_n)
        push_pull |=> !pin.oe_n) else $error("push-pull pin not driven");
    od_low_only_a: assert property (@(posedge clk) disable iff (!rst_n)
        !pin.oe_n && !$past(push_pull) |-> !pin.level)
        else $error("open drain drove high");
endmodule // irq_pin_driver

// ===== rtl/host_link_cfg.sv
/*
 Host link control, irq pin configuration and the interrupt status clear
 logic. Assumes a serial front end turns I2C/SPI frames into one-cycle
 register requests on clk, and the motion block raises one-cycle events.
*/
`timescale 1ns/1ps
`include "host_link_params.svh"

// How it works
// - bits 1:0 of link control always read back as zero.
// - slew enable bit sets pad slew limiting, only in manual mode.
// - manual select at 0 leaves slew to hardware automatic control.
// - route exchange bit swaps which request reaches which pin.
// - shared pin mode makes the serial output pin bidirectional.
// - with per-source clear off, any status write clears all flags.
// - with per-source clear on, each written one clears its flag.
// - first pin asserted level is high when its level bit is set.
// - first pin push-pull when its drive bit is set, else open drain.
// - second pin asserted level is high when its level bit is set.
// - second pin push-pull when its drive bit is set, else open drain.
// - reserved pin configuration bits have no effect.
// - status holds tilt/flip bits 1:0, motion bit 2, shake bit 3.
module host_link_cfg (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register access
    input host_link_pkg::reg_req_t req,
    output logic [7:0] rdata_r,
    // motion block events and request groups
    input wire logic [7:0] event_set,
    input wire logic [7:0] first_req_mask,
    input wire logic [7:0] second_req_mask,
    // serial pad controls
    output host_link_pkg::slew_mode_t pad_slew_r,
    output logic shared_data_pin_mode_r,
    input wire logic serial_out_data,
    input wire logic serial_out_drive,
    output logic serial_out_pin_o_r,
    output logic serial_out_pin_oe_n_r,
    // interrupt pins
    output host_link_pkg::pin_drive_t first_irq_pin,
    output host_link_pkg::pin_drive_t second_irq_pin,
    // status for the front end
    output logic [7:0] irq_status_r
);
    import host_link_pkg::*;

    logic [7:0] link_ctrl_r;
    logic [7:0] pin_cfg_r;
    logic hlc_wr, ipc_wr, ist_wr;
    logic [7:0] clear_bits;
    logic first_irq_request, second_irq_request;
    logic req1_r, req2_r;
    logic per_source_clear_enable, request_route_exchange, pad_slew_manual_select;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    assign hlc_wr = req.wr && hit(req.addr, `HLC_OFFSET);
    assign ipc_wr = req.wr && hit(req.addr, `IPC_OFFSET);
    assign ist_wr = req.wr && hit(req.addr, `IST_OFFSET);
    assign per_source_clear_enable = link_ctrl_r[`HLC_PER_SRC_CLR_BIT];
    assign request_route_exchange = link_ctrl_r[`HLC_ROUTE_XCHG_BIT];
    assign pad_slew_manual_select = link_ctrl_r[`HLC_SLEW_MAN_BIT];

    // link control; low reserved bits never stored, top bit kept as written
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link_ctrl_r <= `HLC_RESET;
        end else if (hlc_wr) begin
            link_ctrl_r <= req.wdata & `HLC_READ_MASK;
        end
    end

    // pin configuration; reserved bits stored but read nowhere
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_cfg_r <= `IPC_RESET;
        end else if (ipc_wr) begin
            pin_cfg_r <= req.wdata;
        end
    end

    // clear mask: everything, or the written bitmask
    always_comb begin
        if (!ist_wr) begin
            clear_bits = 8'h00;
        end else if (per_source_clear_enable) begin
            clear_bits = req.wdata;
        end else begin
            clear_bits = 8'hFF;
        end
    end

    // sticky flags; a new event in the clearing cycle survives
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_status_r <= `IST_RESET;
        end else begin
            irq_status_r <= (irq_status_r & ~clear_bits) | event_set;
        end
    end

    // read data; the pin config register is write only and reads zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (req.rd) begin
            if (hit(req.addr, `HLC_OFFSET)) begin
                rdata_r <= link_ctrl_r & `HLC_READ_MASK;
            end else if (hit(req.addr, `IST_OFFSET)) begin
                rdata_r <= irq_status_r;
            end else begin
                rdata_r <= 8'h00;
            end
        end
    end

    // pad slew selection, slew enable bit only counts in manual mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pad_slew_r <= SLEW_AUTO;
        end else if (!pad_slew_manual_select) begin
            pad_slew_r <= SLEW_AUTO;
        end else begin
            pad_slew_r <= link_ctrl_r[`HLC_SLEW_EN_BIT] ? SLEW_ON : SLEW_OFF;
        end
    end

    // serial out pin: push output normally, turnaround when shared
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shared_data_pin_mode_r <= 1'b0;
            serial_out_pin_o_r <= 1'b0;
            serial_out_pin_oe_n_r <= 1'b1;
        end else begin
            shared_data_pin_mode_r <= link_ctrl_r[`HLC_SHARED_PIN_BIT];
            serial_out_pin_o_r <= serial_out_data;
            if (link_ctrl_r[`HLC_SHARED_PIN_BIT]) begin
                serial_out_pin_oe_n_r <= ~serial_out_drive;
            end else begin
                serial_out_pin_oe_n_r <= 1'b0;
            end
        end
    end

    // request levels from pending flags, then routing exchange
    assign first_irq_request = |(irq_status_r & first_req_mask);
    assign second_irq_request = |(irq_status_r & second_req_mask);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req1_r <= 1'b0;
            req2_r <= 1'b0;
        end else begin
            req1_r <= request_route_exchange ? second_irq_request : first_irq_request;
            req2_r <= request_route_exchange ? first_irq_request : second_irq_request;
        end
    end

    // pin settings follow the physical pin, after the exchange
    irq_pin_driver u_first_pin (
        .clk(clk),
        .rst_n(rst_n),
        .request(req1_r),
        .level_high(pin_cfg_r[`IPC_PIN1_HIGH_BIT]),
        .push_pull(pin_cfg_r[`IPC_PIN1_PP_BIT]),
        .pin(first_irq_pin)
    );

    irq_pin_driver u_second_pin (
        .clk(clk),
        .rst_n(rst_n),
        .request(req2_r),
        .level_high(pin_cfg_r[`IPC_PIN2_HIGH_BIT]),
        .push_pull(pin_cfg_r[`IPC_PIN2_PP_BIT]),
        .pin(second_irq_pin)
    );

    sequence hlc_write_s;
        hlc_wr;
    endsequence

    // only link control reads carry the reserved pair; status bits 1:0 are real flags
    resv_read_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        req.rd && hit(req.addr, `HLC_OFFSET) |=> rdata_r[1:0] == 2'b00)
        else $error("reserved bits read nonzero");
    // pad slew lags the control bit by one cycle, so compare with its past value
    slew_manual_a: assert property (@(posedge clk) disable iff (!rst_n)
        pad_slew_manual_select |=>
        pad_slew_r == ($past(link_ctrl_r[2]) ? SLEW_ON : SLEW_OFF))
        else $error("manual slew wrong");
    slew_auto_a: assert property (@(posedge clk) disable iff (!rst_n)
        !pad_slew_manual_select |=> pad_slew_r == SLEW_AUTO) else $error("auto slew lost");
    route_swap_a: assert property (@(posedge clk) disable iff (!rst_n)
        request_route_exchange |=> req1_r == $past(second_irq_request))
        else $error("routing not exchanged");
    shared_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
        hlc_write_s ##1 1'b1 |=> shared_data_pin_mode_r == $past(link_ctrl_r[5]))
        else $error("shared pin mode not applied");
    clear_all_a: assert property (@(posedge clk) disable iff (!rst_n)
        ist_wr && !per_source_clear_enable |=> irq_status_r == $past(event_set))
        else $error("clear all failed");
    clear_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
        ist_wr && per_source_clear_enable |=>
        irq_status_r == (($past(irq_status_r) & ~$past(req.wdata)) | $past(event_set)))
        else $error("bitmask clear wrong");
    set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
        event_set[3] |=> irq_status_r[3]) else $error("shake event lost");
endmodule // host_link_cfg

// ===== verification/host_model.sv
/*
 Host processor model: issues one-cycle register requests on clk.
 Assumes callers enter its task just after a rising edge.
*/
`timescale 1ns/1ps
module host_model (
    // clock
    input wire logic clk,
    // register requests
    output host_link_pkg::reg_req_t req
);
    import host_link_pkg::*;

    initial req = '0;

    // one request held across one edge, then released with scrambled fields
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        if (a == 8'h31) begin
            d[7] = 1'b0;
        end
        req = '{wr: w, rd: ~w, addr: a, wdata: d};
        @(posedge clk);
        #1;
        req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule // host_model

// ===== verification/tb_top.sv
/*
 Self-checking bench for the host link configuration block.
 Assumes the host model drives requests and the bench drives the rest.
*/
`timescale 1ns/1ps
module tb_top;
    import host_link_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    reg_req_t req;
    logic [7:0] rdata_r, st, c, lf = 8'h1E;
    logic [7:0] ev = 8'h00;
    logic [7:0] m1 = 8'h01;
    logic [7:0] m2 = 8'h02;
    slew_mode_t pad_slew_r;
    logic shared_r, so_r, so_oe_n_r;
    logic sdata = 1'b0;
    logic sdrive = 1'b0;
    pin_drive_t p1, p2;
    int err_total = 0;
    int n_tests = 0;
    int stat_m = 0;

    always #10 clk = ~clk;

    host_model host (.clk(clk), .req(req));

    host_link_cfg dut (.clk(clk), .rst_n(rst_n), .req(req), .rdata_r(rdata_r),
        .event_set(ev), .first_req_mask(m1), .second_req_mask(m2),
        .pad_slew_r(pad_slew_r), .shared_data_pin_mode_r(shared_r),
        .serial_out_data(sdata), .serial_out_drive(sdrive),
        .serial_out_pin_o_r(so_r), .serial_out_pin_oe_n_r(so_oe_n_r),
        .first_irq_pin(p1), .second_irq_pin(p2), .irq_status_r(st));

    function automatic logic [7:0] nxt(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction

    // expected pad drive: push-pull always drives, open drain only pulls low
    function automatic logic [7:0] pin_exp(input logic r, input logic h, input logic pp);
        logic lv;
        lv = r ? h : ~h;
        return pp ? {6'h00, lv, 1'b0} : {6'h00, 1'b0, lv};
    endfunction

    task automatic chk(input logic [7:0] s, input logic [7:0] e, input string m);
        n_tests++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %0t ns %s: seen %h expected %h", $time, m, s, e);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.access(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        host.access(1'b0, a, 8'h00);
        cyc(1);
        chk(rdata_r, e, "read data");
    endtask

    // one-cycle event pulse; the model ors it into the sticky flags
    task automatic pulse(input logic [7:0] e);
        ev = e;
        cyc(1);
        ev = 8'h00;
        stat_m = stat_m | int'(e);
        cyc(2);
    endtask

    task automatic stop_test();
        $display("counts: %0d compares, %0d mismatches", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // hang guard well beyond the few hundred cycles the tests need
    initial begin
        #(20 * 5000);
        err_total++;
        stop_test();
    end

    initial begin
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        cyc(2);
        chk(st, 8'h00, "status reset");
        chk({6'h00, pad_slew_r}, {6'h00, SLEW_AUTO}, "slew reset");
        chk({6'h00, p1}, pin_exp(1'b0, 1'b0, 1'b0), "pin1 reset");
        chk({7'h00, so_oe_n_r}, 8'h00, "serial drive reset");
        rd(8'h31, 8'h00);
        rd(8'h20, 8'h00);
        $display("test reset done");
        repeat (8) begin
            lf = nxt(lf);
            wr(8'h31, lf);
            cyc(2);
            rd(8'h31, lf & 8'h7C);
            chk({6'h00, pad_slew_r}, lf[3] ? {6'h00, lf[2] ? SLEW_ON : SLEW_OFF}
                : {6'h00, SLEW_AUTO}, "slew");
            chk({7'h00, shared_r}, {7'h00, lf[5]}, "shared mode");
        end
        wr(8'h31, 8'h20);
        sdrive = 1'b1;
        sdata = 1'b1;
        cyc(3);
        chk({6'h00, so_r, so_oe_n_r}, 8'h02, "shared drive");
        sdrive = 1'b0;
        cyc(3);
        chk({7'h00, so_oe_n_r}, 8'h01, "shared release");
        $display("test link control done");
        wr(8'h31, 8'h00);
        pulse(8'h0F);
        lf = nxt(lf);
        wr(8'h14, lf);
        stat_m = 0;
        cyc(2);
        chk(st, 8'(stat_m), "clear all");
        wr(8'h31, 8'h40);
        pulse(8'h0F);
        wr(8'h14, 8'h05);
        stat_m = stat_m & ~5;
        cyc(2);
        chk(st, 8'(stat_m), "clear by mask");
        wr(8'h14, 8'h0A);
        stat_m = stat_m & ~10;
        cyc(2);
        chk(st, 8'(stat_m), "clear rest");
        $display("test status clear done");
        pulse(8'h01);
        for (int sw = 0; sw < 2; sw++) begin
            wr(8'h31, sw[0] ? 8'h50 : 8'h40);
            // let an edge pass so the request bus is not driven twice in one step
            cyc(1);
            for (int k = 0; k < 16; k++) begin
                lf = nxt(lf);
                c = (lf & 8'h33) | {k[3], k[2], 2'b00, k[1], k[0], 2'b00};
                wr(8'h33, c);
                cyc(3);
                chk({6'h00, p1}, pin_exp(sw == 0, c[2], c[3]), "pin1");
                chk({6'h00, p2}, pin_exp(sw == 1, c[6], c[7]), "pin2");
            end
        end
        rd(8'h33, 8'h00);
        $display("test irq pins done");
        stop_test();
    end
endmodule // tb_top
